// >>> core/csic_pkg.sv
// constants for the core status and interrupt control block
// assumes a single system clock and a synchronous active-low reset
// ============================================================
package csic_pkg;

  // ============================================================
  // sizes
  localparam int N_SRC       = 22;
  localparam int SRC_IDX_W   = 5;
  localparam int N_PERIPH    = 12;
  localparam int DETECT_CYC  = 1;

  // ============================================================
  // register addresses
  localparam logic [7:0] ADDR_STACK_TOP  = 8'h81;
  localparam logic [7:0] ADDR_PTR_LOW    = 8'h82;
  localparam logic [7:0] ADDR_PTR_HIGH   = 8'h83;
  localparam logic [7:0] ADDR_PEND0      = 8'h84;
  localparam logic [7:0] ADDR_PEND1      = 8'h85;
  localparam logic [7:0] ADDR_PEND2      = 8'h86;
  localparam logic [7:0] ADDR_IRQ_ENABLE = 8'hA8;
  localparam logic [7:0] ADDR_PRIO0      = 8'hB8;
  localparam logic [7:0] ADDR_STATUS     = 8'hD0;
  localparam logic [7:0] ADDR_ARITH_PRI  = 8'hE0;
  localparam logic [7:0] ADDR_EN1        = 8'hE6;
  localparam logic [7:0] ADDR_EN2        = 8'hE7;
  localparam logic [7:0] ADDR_ARITH_SEC  = 8'hF0;
  localparam logic [7:0] ADDR_PRIO1      = 8'hF6;
  localparam logic [7:0] ADDR_PRIO2      = 8'hF7;

  // ============================================================
  // reset values
  localparam logic [7:0] RST_STACK_TOP = 8'h07;
  localparam logic [7:0] RST_ZERO      = 8'h00;

  // ============================================================
  // field positions
  localparam int ST_CARRY   = 7;
  localparam int ST_NIBBLE  = 6;
  localparam int ST_USER0   = 5;
  localparam int ST_BANK_HI = 4;
  localparam int ST_BANK_LO = 3;
  localparam int ST_WRAP    = 2;
  localparam int ST_USER1   = 1;
  localparam int ST_ODD     = 0;
  localparam int EN_GATE    = 7;
  localparam int EN_LOW_W   = 6;
  localparam int PEND2_W    = 6;
  localparam int BANK_SHIFT = 3;
  localparam int VEC_SHIFT  = 3;

  // ============================================================
  // vector layout
  localparam logic [15:0] VEC_BASE = 16'h0003;

  // ============================================================
  // service level states
  typedef enum logic [1:0] {
    CSIC_SVC_IDLE = 2'b00,
    CSIC_SVC_LOW  = 2'b01,
    CSIC_SVC_HIGH = 2'b10,
    CSIC_SVC_BOTH = 2'b11
  } csic_svc_t;

endpackage

// >>> core/csic_irq_arb.sv
// priority decoder for the interrupt sources
// assumes requests are already gated by enables
`timescale 1ns/1ns
module csic_irq_arb #(
  parameter int N_SRC = 22
) (
  // requests and levels
  input  wire logic [N_SRC-1:0]           req,
  input  wire logic [N_SRC-1:0]           prio,
  // selection
  output logic                            found,
  output logic                            is_high,
  output logic [csic_pkg::SRC_IDX_W-1:0]  idx
);
  import csic_pkg::*;

  // ============================================================
  // lowest set index wins within a level
  function automatic logic [SRC_IDX_W-1:0] pick(
    input logic [N_SRC-1:0] m
  );
    logic [SRC_IDX_W-1:0] r;
    r = '0;
    for (int i = N_SRC - 1; i >= 0; i--) begin
      if (m[i]) begin
        r = SRC_IDX_W'(i);
      end
    end
    return r;
  endfunction

  // ============================================================
  // high level first, then fixed order
  always_comb begin
    found   = |req;
    is_high = |(req & prio);
    if (is_high) begin
      idx = pick(req & prio);
    end else begin
      idx = pick(req);
    end
  end

endmodule

// >>> core/csic_core.sv
// core register set with interrupt entry and return control
// assumes the core pulses instruction and return completion strobes
`timescale 1ns/1ns
module csic_core #(
  parameter int                           N_SRC         = 22,
  parameter logic [csic_pkg::N_SRC-1:0]   HW_CLEAR_MASK = 22'h00_0005
) (
  // clock and reset
  input  wire logic                          CLK_SYS,
  input  wire logic                          NRST,
  // special register port
  input  wire logic [7:0]                    SFR_ADDR,
  input  wire logic                          SFR_WR,
  input  wire logic [7:0]                    SFR_WDATA,
  input  wire logic                          SFR_RD,
  output logic      [7:0]                    SFR_RDATA,
  output logic                               SFR_HIT,
  // core datapath updates
  input  wire logic                          STACK_PUSH,
  input  wire logic                          STACK_POP,
  input  wire logic                          ARITH_WE,
  input  wire logic [7:0]                    ARITH_WDATA,
  input  wire logic                          SECOND_WE,
  input  wire logic [7:0]                    SECOND_WDATA,
  input  wire logic                          CARRY_WE,
  input  wire logic                          CARRY_IN,
  input  wire logic                          NIBBLE_CARRY_IN,
  input  wire logic                          WRAP_WE,
  input  wire logic                          WRAP_IN,
  // register views
  output logic      [7:0]                    STACK_TOP,
  output logic      [15:0]                   INDIRECT_PTR,
  output logic      [7:0]                    STATUS_WORD,
  output logic      [7:0]                    ARITH_PRIMARY,
  output logic      [7:0]                    ARITH_SECONDARY,
  output logic      [7:0]                    BANK_BASE,
  // interrupt sources and sequencing
  input  wire logic [csic_pkg::N_SRC-1:0]    IRQ_EVENT,
  input  wire logic                          INSTR_DONE,
  input  wire logic                          RETI_DONE,
  output logic                               IRQ_CALL,
  output logic      [csic_pkg::SRC_IDX_W-1:0] IRQ_SOURCE,
  output logic      [15:0]                   IRQ_VECTOR,
  output logic      [1:0]                    IRQ_LEVEL
);
  import csic_pkg::*;

  if (N_SRC != csic_pkg::N_SRC) begin : g_bad_src
    $error("source count must match the register layout");
  end

  // ============================================================
  // state
  logic [7:0]       stack_top;
  logic [7:0]       ptr_low;
  logic [7:0]       ptr_high;
  logic [7:0]       status;
  logic [7:0]       arith_pri;
  logic [7:0]       arith_sec;
  logic [7:0]       en0;
  logic [7:0]       en1;
  logic [7:0]       en2;
  logic [7:0]       prio0;
  logic [7:0]       prio1;
  logic [7:0]       prio2;
  logic [N_SRC-1:0] pend;
  csic_svc_t        svc;
  logic             req_q;
  logic             req_high_q;
  logic [SRC_IDX_W-1:0] req_idx_q;
  logic [7:0]       next_status;
  logic [7:0]       next_arith;
  logic [N_SRC-1:0] next_pend;
  logic [N_SRC-1:0] enables;
  logic [N_SRC-1:0] levels;
  logic [N_SRC-1:0] gated;
  logic             arb_found;
  logic             arb_high;
  logic [SRC_IDX_W-1:0] arb_idx;
  logic             allowed;
  logic             call_now;
  logic [7:0]       rd_mux;
  logic             rd_hit;

  function automatic logic wr_to(input logic [7:0] a);
    return SFR_WR && (SFR_ADDR == a);
  endfunction

  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);

  // ============================================================
  // stack top pointer
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      stack_top <= RST_STACK_TOP;
    end else if (wr_to(ADDR_STACK_TOP)) begin
      stack_top <= SFR_WDATA;
    end else if (STACK_PUSH) begin
      stack_top <= stack_top + 8'h01;
    end else if (STACK_POP) begin
      stack_top <= stack_top - 8'h01;
    end
  end

  // ============================================================
  // indirect pointer
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      ptr_low  <= RST_ZERO;
      ptr_high <= RST_ZERO;
    end else begin
      if (wr_to(ADDR_PTR_LOW)) begin
        ptr_low <= SFR_WDATA;
      end
      if (wr_to(ADDR_PTR_HIGH)) begin
        ptr_high <= SFR_WDATA;
      end
    end
  end

  // ============================================================
  // arithmetic registers and status word
  always_comb begin
    next_arith = arith_pri;
    if (ARITH_WE) begin
      next_arith = ARITH_WDATA;
    end else if (wr_to(ADDR_ARITH_PRI)) begin
      next_arith = SFR_WDATA;
    end
    next_status = status;
    if (wr_to(ADDR_STATUS)) begin
      next_status = SFR_WDATA;
    end
    if (CARRY_WE) begin
      next_status[ST_CARRY]  = CARRY_IN;
      next_status[ST_NIBBLE] = NIBBLE_CARRY_IN;
    end
    if (WRAP_WE) begin
      next_status[ST_WRAP] = WRAP_IN;
    end
    next_status[ST_ODD] = ^next_arith;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      arith_pri <= RST_ZERO;
      arith_sec <= RST_ZERO;
      status    <= RST_ZERO;
      BANK_BASE <= RST_ZERO;
    end else begin
      arith_pri <= next_arith;
      status    <= next_status;
      BANK_BASE <= {3'b000, next_status[ST_BANK_HI:ST_BANK_LO],
                    3'b000};
      if (SECOND_WE) begin
        arith_sec <= SECOND_WDATA;
      end else if (wr_to(ADDR_ARITH_SEC)) begin
        arith_sec <= SFR_WDATA;
      end
    end
  end

  // ============================================================
  // enables and priority levels
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      en0   <= RST_ZERO;
      en1   <= RST_ZERO;
      en2   <= RST_ZERO;
      prio0 <= RST_ZERO;
      prio1 <= RST_ZERO;
      prio2 <= RST_ZERO;
    end else begin
      if (wr_to(ADDR_IRQ_ENABLE)) begin
        en0 <= SFR_WDATA;
      end
      if (wr_to(ADDR_EN1)) begin
        en1 <= SFR_WDATA;
      end
      if (wr_to(ADDR_EN2)) begin
        en2 <= SFR_WDATA;
      end
      if (wr_to(ADDR_PRIO0)) begin
        prio0 <= {2'b00, SFR_WDATA[EN_LOW_W-1:0]};
      end
      if (wr_to(ADDR_PRIO1)) begin
        prio1 <= SFR_WDATA;
      end
      if (wr_to(ADDR_PRIO2)) begin
        prio2 <= SFR_WDATA;
      end
    end
  end

  assign enables = {en2, en1, en0[EN_LOW_W-1:0]};
  assign levels  = {prio2, prio1, prio0[EN_LOW_W-1:0]};
  assign gated   = pend & enables & {N_SRC{en0[EN_GATE]}};

  // ============================================================
  // pending flags: event set wins over software and vector clear
  always_comb begin
    next_pend = pend;
    if (wr_to(ADDR_PEND0)) begin
      next_pend[7:0] = SFR_WDATA;
    end
    if (wr_to(ADDR_PEND1)) begin
      next_pend[15:8] = SFR_WDATA;
    end
    if (wr_to(ADDR_PEND2)) begin
      next_pend[N_SRC-1:16] = SFR_WDATA[PEND2_W-1:0];
    end
    if (call_now && HW_CLEAR_MASK[req_idx_q]) begin
      next_pend[req_idx_q] = 1'b0;
    end
    next_pend = next_pend | IRQ_EVENT;
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      pend <= '0;
    end else begin
      pend <= next_pend;
    end
  end

  // ============================================================
  // decode each cycle, call at instruction end
  csic_irq_arb #(
    .N_SRC (N_SRC)
  ) u_arb (
    .req     (gated),
    .prio    (levels),
    .found   (arb_found),
    .is_high (arb_high),
    .idx     (arb_idx)
  );

  always_comb begin
    case (svc)
      CSIC_SVC_IDLE: allowed = arb_found;
      CSIC_SVC_LOW:  allowed = arb_high || RETI_DONE;
      CSIC_SVC_HIGH: allowed = RETI_DONE;
      default:       allowed = RETI_DONE && arb_high;
    endcase
  end

  assign call_now = INSTR_DONE && req_q && !RETI_DONE
                    && !IRQ_CALL && en0[EN_GATE];

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      req_q      <= 1'b0;
      req_high_q <= 1'b0;
      req_idx_q  <= '0;
    end else begin
      req_q      <= arb_found && allowed;
      req_high_q <= arb_high;
      req_idx_q  <= arb_idx;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      IRQ_CALL   <= 1'b0;
      IRQ_SOURCE <= '0;
      IRQ_VECTOR <= VEC_BASE;
    end else begin
      IRQ_CALL <= call_now;
      if (call_now) begin
        IRQ_SOURCE <= req_idx_q;
        IRQ_VECTOR <= VEC_BASE + (16'(req_idx_q) << VEC_SHIFT);
      end
    end
  end

  // ============================================================
  // service level tracking
  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      svc <= CSIC_SVC_IDLE;
    end else begin
      case (svc)
        CSIC_SVC_IDLE: begin
          if (call_now) begin
            svc <= req_high_q ? CSIC_SVC_HIGH : CSIC_SVC_LOW;
          end
        end
        CSIC_SVC_LOW: begin
          if (call_now) begin
            svc <= CSIC_SVC_BOTH;
          end else if (RETI_DONE) begin
            svc <= CSIC_SVC_IDLE;
          end
        end
        CSIC_SVC_HIGH: begin
          if (RETI_DONE) begin
            svc <= CSIC_SVC_IDLE;
          end
        end
        default: begin
          if (RETI_DONE) begin
            svc <= CSIC_SVC_LOW;
          end
        end
      endcase
    end
  end

  // ============================================================
  // register read port
  always_comb begin
    rd_hit = 1'b1;
    if (SFR_ADDR == ADDR_STACK_TOP) begin
      rd_mux = stack_top;
    end else if (SFR_ADDR == ADDR_PTR_LOW) begin
      rd_mux = ptr_low;
    end else if (SFR_ADDR == ADDR_PTR_HIGH) begin
      rd_mux = ptr_high;
    end else if (SFR_ADDR == ADDR_PEND0) begin
      rd_mux = pend[7:0];
    end else if (SFR_ADDR == ADDR_PEND1) begin
      rd_mux = pend[15:8];
    end else if (SFR_ADDR == ADDR_PEND2) begin
      rd_mux = {2'b00, pend[N_SRC-1:16]};
    end else if (SFR_ADDR == ADDR_IRQ_ENABLE) begin
      rd_mux = en0;
    end else if (SFR_ADDR == ADDR_EN1) begin
      rd_mux = en1;
    end else if (SFR_ADDR == ADDR_EN2) begin
      rd_mux = en2;
    end else if (SFR_ADDR == ADDR_PRIO0) begin
      rd_mux = prio0;
    end else if (SFR_ADDR == ADDR_PRIO1) begin
      rd_mux = prio1;
    end else if (SFR_ADDR == ADDR_PRIO2) begin
      rd_mux = prio2;
    end else if (SFR_ADDR == ADDR_STATUS) begin
      rd_mux = status;
    end else if (SFR_ADDR == ADDR_ARITH_PRI) begin
      rd_mux = arith_pri;
    end else if (SFR_ADDR == ADDR_ARITH_SEC) begin
      rd_mux = arith_sec;
    end else begin
      rd_mux = RST_ZERO;
      rd_hit = 1'b0;
    end
  end

  always_ff @(posedge CLK_SYS) begin
    if (!NRST) begin
      SFR_RDATA <= RST_ZERO;
      SFR_HIT   <= 1'b0;
    end else begin
      SFR_HIT <= SFR_RD && rd_hit;
      if (SFR_RD) begin
        SFR_RDATA <= rd_mux;
      end
    end
  end

  assign STACK_TOP       = stack_top;
  assign INDIRECT_PTR    = {ptr_high, ptr_low};
  assign STATUS_WORD     = status;
  assign ARITH_PRIMARY   = arith_pri;
  assign ARITH_SECONDARY = arith_sec;
  assign IRQ_LEVEL       = svc;

  // ============================================================
  // checks
  a_push_step: assert property (
    STACK_PUSH && !SFR_WR |=> stack_top == $past(stack_top) + 8'h01)
    else $error("push did not advance stack top by one");
  a_odd_ones: assert property (
    status[ST_ODD] == ^arith_pri)
    else $error("odd-ones bit disagrees with primary register");
  a_bank_map: assert property (
    BANK_BASE == {3'b000, status[ST_BANK_HI:ST_BANK_LO], 3'b000})
    else $error("bank base does not follow bank select");
  a_user_flags: assert property (
    !wr_to(ADDR_STATUS) |=> $stable(status[ST_USER0])
                             && $stable(status[ST_USER1]))
    else $error("user flag changed without software write");
  a_carry_load: assert property (
    CARRY_WE |=> status[ST_CARRY] == $past(CARRY_IN)
                 && status[ST_NIBBLE] == $past(NIBBLE_CARRY_IN))
    else $error("carry flags not loaded from arithmetic result");
  a_wrap_load: assert property (
    WRAP_WE |=> status[ST_WRAP] == $past(WRAP_IN))
    else $error("sign wrap flag not loaded");
  a_event_sets: assert property (
    IRQ_EVENT != '0 |=> (pend & $past(IRQ_EVENT)) == $past(IRQ_EVENT))
    else $error("event lost from pending flags");
  a_gate_blocks: assert property (
    !en0[EN_GATE] |=> !IRQ_CALL)
    else $error("call issued with global gate closed");
  a_no_call_reti: assert property (
    RETI_DONE |=> !IRQ_CALL)
    else $error("call issued on the return instruction");
  a_call_taken: assert property (
    INSTR_DONE && req_q && en0[EN_GATE] && !RETI_DONE && !IRQ_CALL
    |=> IRQ_CALL ##0 IRQ_VECTOR == VEC_BASE + (16'(IRQ_SOURCE) << VEC_SHIFT))
    else $error("pending request not called at instruction end");
  a_high_no_preempt: assert property (
    svc == CSIC_SVC_HIGH && !RETI_DONE |=> svc == CSIC_SVC_HIGH)
    else $error("high level service was preempted");

  c_low_call:  cover property (IRQ_CALL && svc == CSIC_SVC_LOW);
  c_nested:    cover property (svc == CSIC_SVC_BOTH);
  c_return:    cover property (svc == CSIC_SVC_LOW && RETI_DONE);
  c_sw_event:  cover property (wr_to(ADDR_PEND0) ##[1:10] IRQ_CALL);

endmodule

// >>> tb/csic_src_model.sv
// interrupt source model: peripherals and pins raising pending events
// assumes the bench picks a source and pulses fire on the falling edge
`timescale 1ns/1ns
module csic_src_model (
  // control
  input  wire logic                           clk,
  input  wire logic [csic_pkg::SRC_IDX_W-1:0] sel,
  input  wire logic                           fire,
  // events
  output logic      [csic_pkg::N_SRC-1:0]     irq_event
);
  import csic_pkg::*;
  logic fire_q;
  initial irq_event = '0;
  initial fire_q = 1'b0;
  // ============================================================
  // one-cycle event on any of the sources
  always @(posedge clk) begin
    fire_q <= fire;
  end
  always @(negedge clk) begin
    irq_event <= fire_q ? (N_SRC'(1) << sel) : '0;
  end
endmodule

// >>> tb/csic_core_tb.sv
// self-checking bench for the core register and interrupt block
// assumes the core package and a source model on the event inputs
`timescale 1ns/1ns
module csic_core_tb;
  import csic_pkg::*;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, awd = 8'h00, swd = 8'h00;
  logic        wr = 1'b0, rd = 1'b0, push = 1'b0, pop = 1'b0;
  logic        awe = 1'b0, swe = 1'b0, cwe = 1'b0, vwe = 1'b0;
  logic        cin = 1'b0, nin = 1'b0, vin = 1'b0;
  logic        instr = 1'b0, reti = 1'b0, fire = 1'b0, got;
  logic [4:0]  sel = 5'h00;
  logic [4:0]  src;
  logic [21:0] ev;
  logic [7:0]  rdata, sp, st, pa, sa, bank;
  logic [15:0] ptr, vec;
  logic        hit, call;
  logic [1:0]  lvl;
  int          err_total = 0;
  int          checks_done = 0;
  int          cyc = 0;

  always #20 clk_sys = ~clk_sys;

  csic_src_model src_u (.clk(clk_sys), .sel(sel), .fire(fire), .irq_event(ev));

  csic_core dut_u (
    .CLK_SYS(clk_sys), .NRST(nrst),
    .SFR_ADDR(addr), .SFR_WR(wr), .SFR_WDATA(wdata), .SFR_RD(rd),
    .SFR_RDATA(rdata), .SFR_HIT(hit),
    .STACK_PUSH(push), .STACK_POP(pop),
    .ARITH_WE(awe), .ARITH_WDATA(awd), .SECOND_WE(swe), .SECOND_WDATA(swd),
    .CARRY_WE(cwe), .CARRY_IN(cin), .NIBBLE_CARRY_IN(nin),
    .WRAP_WE(vwe), .WRAP_IN(vin),
    .STACK_TOP(sp), .INDIRECT_PTR(ptr), .STATUS_WORD(st),
    .ARITH_PRIMARY(pa), .ARITH_SECONDARY(sa), .BANK_BASE(bank),
    .IRQ_EVENT(ev), .INSTR_DONE(instr), .RETI_DONE(reti),
    .IRQ_CALL(call), .IRQ_SOURCE(src), .IRQ_VECTOR(vec), .IRQ_LEVEL(lvl)
  );

  // ============================================================
  // shared tasks
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks_done, err_total);
    if (err_total == 0 && checks_done > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic pulse(ref logic s);
    @(negedge clk_sys);
    s = 1'b1;
    @(negedge clk_sys);
    s = 1'b0;
  endtask

  task automatic wreg(input logic [7:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    pulse(wr);
  endtask

  task automatic rreg(input logic [7:0] a, input logic [7:0] e,
                      input logic h);
    addr = a;
    pulse(rd);
    chk(rdata, e);
    chk(hit, h);
  endtask

  task automatic run(input int n);
    got = 1'b0;
    for (int i = 0; i < n && !got; i++) begin
      @(negedge clk_sys);
      got = (call === 1'b1);
      instr = !got;
    end
    @(negedge clk_sys);
    instr = 1'b0;
  endtask

  task automatic ecall(input logic [4:0] s, input logic [1:0] l);
    run(12);
    chk(got, 1'b1);
    chk(src, s);
    chk(vec, VEC_BASE + (16'(s) << VEC_SHIFT));
    chk(lvl, l);
  endtask

  task automatic ret(input logic [1:0] l);
    @(negedge clk_sys);
    reti = 1'b1;
    instr = 1'b1;
    @(negedge clk_sys);
    reti = 1'b0;
    instr = 1'b0;
    chk(lvl, l);
  endtask

  task automatic ret_hold(input logic [4:0] s);
    @(negedge clk_sys);
    reti = 1'b1;
    instr = 1'b1;
    @(negedge clk_sys);
    reti = 1'b0;
    chk(lvl, 2'd0);
    @(negedge clk_sys);
    instr = 1'b0;
    chk(call, 1'b1);
    chk(src, s);
    chk(vec, VEC_BASE + (16'(s) << VEC_SHIFT));
    chk(lvl, 2'd1);
  endtask

  // ============================================================
  // scenarios
  task automatic t_regs;
    rreg(ADDR_STACK_TOP, RST_STACK_TOP, 1'b1);
    rreg(ADDR_ARITH_SEC, RST_ZERO, 1'b1);
    rreg(8'h9C, RST_ZERO, 1'b0);
    pulse(push);
    chk(sp, 8'h08);
    pulse(pop);
    chk(sp, RST_STACK_TOP);
    wreg(ADDR_PTR_LOW, 8'h34);
    wreg(ADDR_PTR_HIGH, 8'h12);
    chk(ptr, 16'h1234);
    wreg(ADDR_ARITH_PRI, 8'h07);
    chk(pa, 8'h07);
    chk(st, 8'h01);
    for (int b = 0; b < 4; b++) begin
      wreg(ADDR_STATUS, 8'h22 | 8'(b << BANK_SHIFT));
      chk(bank, 8'(b << BANK_SHIFT));
    end
    rreg(ADDR_STATUS, 8'h3B, 1'b1);
    awd = 8'h03;
    pulse(awe);
    chk(st, 8'h3A);
    swd = 8'h5A;
    pulse(swe);
    chk(sa, 8'h5A);
    $display("register test done");
  endtask

  task automatic flags(input logic v);
    cin = v;
    nin = v;
    vin = v;
    @(negedge clk_sys);
    cwe = 1'b1;
    vwe = 1'b1;
    @(negedge clk_sys);
    cwe = 1'b0;
    vwe = 1'b0;
  endtask

  task automatic t_flags;
    flags(1'b1);
    chk(st, 8'hFE);
    flags(1'b0);
    chk(st, 8'h3A);
    $display("flag test done");
  endtask

  task automatic t_irq;
    wreg(ADDR_IRQ_ENABLE, 8'h80);
    sel = 5'd1;
    pulse(fire);
    run(8);
    chk(got, 1'b0);
    rreg(ADDR_PEND0, 8'h02, 1'b1);
    wreg(ADDR_IRQ_ENABLE, 8'h02);
    run(8);
    chk(got, 1'b0);
    wreg(ADDR_IRQ_ENABLE, 8'h82);
    ecall(5'd1, 2'd1);
    ret_hold(5'd1);
    wreg(ADDR_PEND0, 8'h00);
    ret(2'd0);
    run(8);
    chk(got, 1'b0);
    wreg(ADDR_IRQ_ENABLE, 8'hA0);
    wreg(ADDR_PEND0, 8'h20);
    ecall(5'd5, 2'd1);
    wreg(ADDR_PEND0, 8'h00);
    ret(2'd0);
    wreg(ADDR_PRIO0, 8'h08);
    wreg(ADDR_IRQ_ENABLE, 8'h8C);
    wreg(ADDR_PEND0, 8'h0C);
    ecall(5'd3, 2'd2);
    wreg(ADDR_PEND0, 8'h04);
    ret(2'd0);
    ecall(5'd2, 2'd1);
    rreg(ADDR_PEND0, 8'h00, 1'b1);
    wreg(ADDR_PEND0, 8'h08);
    ecall(5'd3, 2'd3);
    wreg(ADDR_PEND0, 8'h00);
    ret(2'd1);
    ret(2'd0);
    wreg(ADDR_EN2, 8'h80);
    sel = 5'd21;
    pulse(fire);
    ecall(5'd21, 2'd1);
    $display("interrupt test done");
  endtask

  // ============================================================
  // hang guard and main sequence
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_total++;
      final_report;
    end
  end

  initial begin
    repeat (2) @(negedge clk_sys);
    nrst = 1'b1;
    t_regs;
    t_flags;
    t_irq;
    final_report;
  end
endmodule
